/* File: shared/asc_pkg.sv */
// Purpose: Constants and carrier types for the axis stop control block
// Assumes: One reference clock, four axes, no register bus
// Notes: Summary of operation below
//
// Summary of operation
// [RQ1] Axis obeys shared stop line only when its stop-line enable bit 24 is set.
// [RQ2] Simultaneous stop command 07h pulses the shared stop line for 8 clocks.
// [RQ3] Error halt on an axis with auto output set pulses the line 8 clocks.
// [RQ4] An outside circuit holds the line active at least 4 clocks per stop.
// [RQ5] Environment bit 19 picks immediate stop (0) or deceleration stop (1).
// [RQ6] Extension status bit 6 shows the shared stop line, 1 while active.
// [RQ7] Error cause bit 8 sets when an axis stopped on the shared stop line.
// [RQ8] The ordinary stop command halts only the selected axes, line untouched.
// [RQ9] Emergency input low or emergency command stops every running axis at once.
// [RQ10] While the emergency input stays low no axis may start or run.
// [RQ11] Emergency input is fixed active low with no polarity choice.
// [RQ12] An emergency halt raises the interrupt output and records its cause.
// [RQ13] Extension status bit 7 shows the emergency input, 1 while active.
// [RQ14] Error cause bit 9 sets when axes stopped on the emergency input.
// [RQ15] Emergency command 05h behaves exactly like an active emergency input; the code stops axes and records causes but sets no start inhibit or bit 7.
// [RQ16] Software performs an origin return after every emergency stop.
// [RQ17] Enabled axis stops while the shared line is low; polarity is fixed.
// [RQ18] Deceleration stop applies only to high speed starts, else immediate.
// [RQ19] A stop from the shared line can raise the interrupt output.
// [RQ20] The shared line is only pulled low or released, wired-AND style.

package asc_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NUM_AXES = 4;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_STOP_LINE_EN_BIT = 24;
	localparam int MODE_AUTO_OUT_BIT = 25;
	localparam int ENV1_STOP_METHOD_BIT = 19;
	localparam int XSTAT_LINE_BIT = 6;
	localparam int XSTAT_EMG_BIT = 7;
	localparam int ECAUSE_LINE_BIT = 8;
	localparam int ECAUSE_EMG_BIT = 9;

	// ----------------------------------------------------------------
	// Commands, counts and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_EMG_STOP = 8'h05;
	localparam logic [7:0] CMD_SIM_STOP = 8'h07;
	localparam logic [7:0] CMD_AXIS_STOP = 8'h49;
	localparam logic [3:0] PULSE_CYCLES = 4'h8;
	localparam logic [3:0] PULSE_IDLE = 4'h0;
	localparam logic [7:0] XSTAT_RST = 8'h00;
	localparam logic [15:0] ECAUSE_RST = 16'h0000;

	// Command write carrier
	typedef struct packed {
		logic valid;
		logic [NUM_AXES-1:0] axis_mask;
		logic [7:0] code;
	} asc_cmd_t;

	// Pulse generator states
	typedef enum logic [1:0] {
		ASC_IDLE = 2'b01,
		ASC_DRIVE = 2'b10
	} asc_pulse_state_t;

endpackage

/* File: design/asc_axis_stop_control.sv */
// Purpose: Shared stop line and emergency stop handling for four axes
// Assumes: Axis sequencers act on the stop and inhibit outputs
// Notes: Shared line is open drain, driven low only when enabled

`timescale 1ns/1ps

module asc_axis_stop_control (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Command write
	input wire asc_pkg::asc_cmd_t i_cmd,
	// Per-axis configuration words
	input wire logic [asc_pkg::NUM_AXES-1:0][31:0] i_op_mode,
	input wire logic [asc_pkg::NUM_AXES-1:0][31:0] i_env_one,
	// Per-axis motion state
	input wire logic [asc_pkg::NUM_AXES-1:0] i_axis_running,
	input wire logic [asc_pkg::NUM_AXES-1:0] i_high_speed,
	input wire logic [asc_pkg::NUM_AXES-1:0] i_axis_error_stop,
	input wire logic [asc_pkg::NUM_AXES-1:0] i_err_cause_clr,
	// Pins
	input wire logic i_shared_stop_line,
	input wire logic i_emergency_stop_input_n,
	output logic o_shared_stop_line_out,
	output logic o_shared_stop_line_oe,
	// Axis control
	output logic [asc_pkg::NUM_AXES-1:0] o_stop_immediate,
	output logic [asc_pkg::NUM_AXES-1:0] o_stop_decel,
	output logic o_start_inhibit,
	// Status
	output logic [asc_pkg::NUM_AXES-1:0][7:0] o_ext_status,
	output logic [asc_pkg::NUM_AXES-1:0][15:0] o_err_cause,
	output logic [asc_pkg::NUM_AXES-1:0] o_irq
);

	localparam int N = asc_pkg::NUM_AXES;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic line_s1_q;
	logic line_s2_q;
	logic emg_s1_q;
	logic emg_s2_q;
	logic line_act;
	logic emg_pin_act;
	logic emg_cmd;
	logic emg_act;

	// Two flops per pin, idle high
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			line_s1_q <= 1'b1;
			line_s2_q <= 1'b1;
			emg_s1_q <= 1'b1;
			emg_s2_q <= 1'b1;
		end else begin
			line_s1_q <= i_shared_stop_line;
			line_s2_q <= line_s1_q;
			emg_s1_q <= i_emergency_stop_input_n;
			emg_s2_q <= emg_s1_q;
		end
	end

	// Fixed active-low decode, command folds into emergency
	assign line_act = !line_s2_q; // [RQ17]
	assign emg_pin_act = !emg_s2_q; // [RQ11]
	assign emg_cmd = i_cmd.valid && (i_cmd.code == asc_pkg::CMD_EMG_STOP);
	assign emg_act = emg_pin_act || emg_cmd; // [RQ15]

	// ----------------------------------------------------------------
	// Stop line pulse generator
	// ----------------------------------------------------------------
	asc_pkg::asc_pulse_state_t pulse_state_q;
	logic [3:0] pulse_cnt_q;
	logic sim_cmd;
	logic err_trig;
	logic [N-1:0] auto_out;
	logic pulse_trig;

	assign sim_cmd = i_cmd.valid && (i_cmd.code == asc_pkg::CMD_SIM_STOP) && (|i_cmd.axis_mask);
	assign err_trig = |(i_axis_error_stop & auto_out); // [RQ3]
	assign pulse_trig = sim_cmd || err_trig; // [RQ2]

	// One shot of fixed width, new triggers ignored while driving
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			pulse_state_q <= asc_pkg::ASC_IDLE;
			pulse_cnt_q <= asc_pkg::PULSE_IDLE;
		end else begin
			unique case (pulse_state_q)
				asc_pkg::ASC_IDLE: begin
					if (pulse_trig) begin
						pulse_state_q <= asc_pkg::ASC_DRIVE;
						pulse_cnt_q <= asc_pkg::PULSE_CYCLES; // [RQ2] [RQ3]
					end
				end
				asc_pkg::ASC_DRIVE: begin
					pulse_cnt_q <= pulse_cnt_q - 4'h1;
					if (pulse_cnt_q == 4'h1) begin
						pulse_state_q <= asc_pkg::ASC_IDLE;
					end
				end
				default: begin
					pulse_state_q <= asc_pkg::ASC_IDLE;
					pulse_cnt_q <= asc_pkg::PULSE_IDLE;
				end
			endcase
		end
	end

	// Open drain: level fixed low, only the enable moves
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_shared_stop_line_out <= 1'b0;
			o_shared_stop_line_oe <= 1'b0;
		end else begin
			o_shared_stop_line_out <= 1'b0; // [RQ20]
			o_shared_stop_line_oe <= pulse_trig && (pulse_state_q == asc_pkg::ASC_IDLE) ||
				(pulse_state_q == asc_pkg::ASC_DRIVE) && (pulse_cnt_q != 4'h1); // [RQ20]
		end
	end

	// ----------------------------------------------------------------
	// Per-axis stop, status and cause
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_start_inhibit <= 1'b0;
		end else begin
			o_start_inhibit <= emg_pin_act; // [RQ10]
		end
	end

	for (genvar g = 0; g < N; g++) begin : g_axis
		logic line_en;
		logic decel_sel;
		logic line_stop;
		logic own_stop;
		logic set_line;
		logic set_emg;

		assign line_en = i_op_mode[g][asc_pkg::MODE_STOP_LINE_EN_BIT]; // [RQ1]
		assign auto_out[g] = i_op_mode[g][asc_pkg::MODE_AUTO_OUT_BIT];
		assign decel_sel = i_env_one[g][asc_pkg::ENV1_STOP_METHOD_BIT] && i_high_speed[g]; // [RQ5] [RQ18]
		assign line_stop = line_act && line_en && i_axis_running[g]; // [RQ1] [RQ17]
		assign own_stop = i_cmd.valid && (i_cmd.code == asc_pkg::CMD_AXIS_STOP) && i_cmd.axis_mask[g]; // [RQ8]
		assign set_line = line_stop;
		assign set_emg = emg_act && i_axis_running[g];

		// Stop requests, emergency overrides deceleration
		always_ff @(posedge i_sys_clk) begin
			if (!i_nrst) begin
				o_stop_immediate[g] <= 1'b0;
				o_stop_decel[g] <= 1'b0;
			end else begin
				o_stop_immediate[g] <= emg_act || own_stop || (line_stop && !decel_sel); // [RQ9] [RQ5]
				o_stop_decel[g] <= line_stop && decel_sel && !emg_act && !own_stop; // [RQ5] [RQ18]
			end
		end

		// Live pin status
		always_ff @(posedge i_sys_clk) begin
			if (!i_nrst) begin
				o_ext_status[g] <= asc_pkg::XSTAT_RST;
			end else begin
				o_ext_status[g] <= asc_pkg::XSTAT_RST;
				o_ext_status[g][asc_pkg::XSTAT_LINE_BIT] <= line_act; // [RQ6]
				o_ext_status[g][asc_pkg::XSTAT_EMG_BIT] <= emg_pin_act; // [RQ13]
			end
		end

		// Sticky causes, set wins over clear
		always_ff @(posedge i_sys_clk) begin
			if (!i_nrst) begin
				o_err_cause[g] <= asc_pkg::ECAUSE_RST;
			end else begin
				o_err_cause[g][asc_pkg::ECAUSE_LINE_BIT] <= set_line ||
					(o_err_cause[g][asc_pkg::ECAUSE_LINE_BIT] && !i_err_cause_clr[g]); // [RQ7]
				o_err_cause[g][asc_pkg::ECAUSE_EMG_BIT] <= set_emg ||
					(o_err_cause[g][asc_pkg::ECAUSE_EMG_BIT] && !i_err_cause_clr[g]); // [RQ14] [RQ12]
			end
		end

		// Interrupt request follows any pending cause
		always_ff @(posedge i_sys_clk) begin
			if (!i_nrst) begin
				o_irq[g] <= 1'b0;
			end else begin
				o_irq[g] <= set_line || set_emg ||
					((o_err_cause[g][asc_pkg::ECAUSE_LINE_BIT] || o_err_cause[g][asc_pkg::ECAUSE_EMG_BIT])
					&& !i_err_cause_clr[g]); // [RQ12] [RQ19]
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	a_pulse_width: assert property ($rose(o_shared_stop_line_oe) |-> // [RQ2]
		o_shared_stop_line_oe [*8] ##1 !o_shared_stop_line_oe)
		else $error("stop line pulse not eight cycles");
	a_sim_cmd_pulse: assert property (sim_cmd && pulse_state_q == asc_pkg::ASC_IDLE // [RQ2]
		|=> $rose(o_shared_stop_line_oe))
		else $error("stop command gave no pulse");
	a_error_pulse: assert property (err_trig && pulse_state_q == asc_pkg::ASC_IDLE |=> o_shared_stop_line_oe) // [RQ3]
		else $error("error stop gave no pulse");
	a_drive_low: assert property (o_shared_stop_line_oe |-> !o_shared_stop_line_out) // [RQ20]
		else $error("stop line driven high");
	a_line_status: assert property (o_ext_status[0][asc_pkg::XSTAT_LINE_BIT] == !$past(line_s2_q)) // [RQ6]
		else $error("line status mismatch");
	a_emg_status: assert property ($fell(emg_s2_q) // [RQ13]
		|=> o_ext_status[0][asc_pkg::XSTAT_EMG_BIT] && o_start_inhibit)
		else $error("emergency status or inhibit missing");
	a_emg_stop_all: assert property (emg_act |=> (&o_stop_immediate) && !(|o_stop_decel)) // [RQ9]
		else $error("emergency did not stop all axes");
	a_line_cause: assert property (line_act && i_op_mode[0][asc_pkg::MODE_STOP_LINE_EN_BIT] && i_axis_running[0] // [RQ7]
		|=> o_err_cause[0][asc_pkg::ECAUSE_LINE_BIT] && o_irq[0])
		else $error("line cause not recorded");
	a_emg_cause: assert property (emg_cmd && i_axis_running[1] // [RQ14]
		|=> o_err_cause[1][asc_pkg::ECAUSE_EMG_BIT] && o_irq[1])
		else $error("emergency cause not recorded");
	a_line_ignored: assert property (!i_op_mode[1][asc_pkg::MODE_STOP_LINE_EN_BIT] && !emg_act // [RQ1]
		&& !(i_cmd.valid && i_cmd.code == asc_pkg::CMD_AXIS_STOP) |=> !o_stop_immediate[1] && !o_stop_decel[1])
		else $error("disabled axis reacted to line");

	c_sim_pulse: cover property ($rose(o_shared_stop_line_oe) ##8 !o_shared_stop_line_oe);
	c_decel_stop: cover property (o_stop_decel[3]);
	c_emg_cause: cover property (o_err_cause[0][asc_pkg::ECAUSE_EMG_BIT]);
	c_own_stop: cover property (i_cmd.valid && i_cmd.code == asc_pkg::CMD_AXIS_STOP ##1 o_stop_immediate[2]);

endmodule

/* File: test/asc_far_side.sv */
// Purpose: Far-side stop source on the shared stop line
// Assumes: Another chip or an outside circuit, open drain only
// Notes: Pulls the line low for a given count, then releases it to the pull-up

`timescale 1ns/1ps

module asc_far_side (
	// Clock
	input wire logic i_sys_clk,
	// Request
	input wire logic i_fire,
	input wire logic [3:0] i_len,
	// Pin
	output logic o_pull_oe
);
	logic [3:0] left_q = 4'h0;

	// ----------------------------------------------------------------
	// Pulse timer
	// ----------------------------------------------------------------
	// Load the requested length, count down to release
	always_ff @(posedge i_sys_clk) begin
		if (i_fire) begin
			left_q <= i_len;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end
	end

	// Only ever pull low; a high level comes from the pull-up
	assign o_pull_oe = (left_q != 4'h0);
endmodule

/* File: test/asc_axis_stop_control_tb.sv */
// Purpose: Self-checking bench for the axis stop control block
// Assumes: Axes 0,2,3 obey the line, axis 2 has auto output, axes 2,3 high speed
// Notes: Outputs are gathered at falling edges between clears

`timescale 1ns/1ps

module asc_axis_stop_control_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	asc_pkg::asc_cmd_t cmd = '0;
	logic [3:0][31:0] mode = {32'h01000000, 32'h03000000, 32'h00000000, 32'h01000000};
	logic [3:0][31:0] env = {32'h00080000, 32'h00000000, 32'h00000000, 32'h00080000};
	logic [3:0] run = 4'hF;
	logic [3:0] hs = 4'hC;
	logic [3:0] estop = 4'h0;
	logic [3:0] cclr = 4'h0;
	logic emg_n = 1'b1;
	logic fire = 1'b0;
	logic line, oe, out, far_oe, inh, a_inh;
	logic [3:0] imm, dec, irq, a_imm, a_dec, a_s6, a_s7;
	logic [3:0][7:0] xst;
	logic [3:0][15:0] ec;
	int oe_cnt = 0;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;

	// ----------------------------------------------------------------
	// Clock, wire, instances
	// ----------------------------------------------------------------
	always #25 clk = ~clk;
	// Wired-AND line with pull-up
	assign line = (oe ? out : 1'b1) & ~far_oe;

	asc_axis_stop_control uut (.i_sys_clk(clk), .i_nrst(nrst), .i_cmd(cmd), .i_op_mode(mode), .i_env_one(env),
		.i_axis_running(run), .i_high_speed(hs), .i_axis_error_stop(estop), .i_err_cause_clr(cclr),
		.i_shared_stop_line(line), .i_emergency_stop_input_n(emg_n), .o_shared_stop_line_out(out),
		.o_shared_stop_line_oe(oe), .o_stop_immediate(imm), .o_stop_decel(dec), .o_start_inhibit(inh),
		.o_ext_status(xst), .o_err_cause(ec), .o_irq(irq));
	asc_far_side far (.i_sys_clk(clk), .i_fire(fire), .i_len(4'h4), .o_pull_oe(far_oe));

	// ----------------------------------------------------------------
	// Observation and helpers
	// ----------------------------------------------------------------
	// Gather what was seen since the last clear
	always @(negedge clk) begin
		for (int i = 0; i < 4; i++) begin
			a_s6[i] |= xst[i][6];
			a_s7[i] |= xst[i][7];
		end
		a_imm |= imm;
		a_dec |= dec;
		a_inh |= inh;
		if (oe === 1'b1) oe_cnt++;
	end

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			give_verdict();
		end
	end

	function automatic logic [3:0] cbit(input int b);
		for (int i = 0; i < 4; i++) cbit[i] = ec[i][b];
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic clr();
		{a_imm, a_dec, a_s6, a_s7, a_inh} = '0;
		oe_cnt = 0;
	endtask

	task automatic send(input logic [7:0] code, input logic [3:0] mask);
		cmd <= '{valid: 1'b1, axis_mask: mask, code: code};
		tick(1);
		cmd.valid <= 1'b0;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Clear all causes, interrupt must drop
	task automatic uncause();
		cclr <= 4'hF;
		tick(1);
		cclr <= 4'h0;
		tick(2);
		chk(ec[0] | ec[1] | ec[2] | ec[3], 16'h0000);
		chk({12'h0, irq}, 16'h0000);
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		tick(6);
		nrst <= 1'b1;
		tick(2);
		// Simultaneous stop, retrigger mid-pulse dropped
		clr();
		send(8'h07, 4'hF);
		tick(2);
		send(8'h07, 4'hF);
		tick(20);
		chk(16'(oe_cnt), 16'h0008);
		chk({12'h0, a_imm}, 16'h0005);
		chk({12'h0, a_dec}, 16'h0008);
		chk({12'h0, a_s6}, 16'h000F);
		chk({12'h0, cbit(8)}, 16'h000D);
		chk({12'h0, irq}, 16'h000D);
		chk({15'h0, a_inh}, 16'h0000);
		uncause();
		// Shortest outside pulse
		clr();
		fire <= 1'b1;
		tick(1);
		fire <= 1'b0;
		tick(20);
		chk({12'h0, a_imm}, 16'h0005);
		chk({12'h0, a_dec}, 16'h0008);
		chk(16'(oe_cnt), 16'h0000);
		uncause();
		// Error halt without, then with auto output
		for (int k = 0; k < 2; k++) begin
			clr();
			estop <= k ? 4'h4 : 4'h1;
			tick(1);
			estop <= 4'h0;
			tick(20);
			chk(16'(oe_cnt), k ? 16'h0008 : 16'h0000);
			uncause();
		end
		// Per-axis stop leaves the line alone
		clr();
		send(8'h49, 4'h4);
		tick(5);
		chk({12'h0, a_imm}, 16'h0004);
		chk(16'(oe_cnt), 16'h0000);
		// Emergency input held low
		clr();
		emg_n <= 1'b0;
		tick(10);
		chk({12'h0, a_imm}, 16'h000F);
		chk({12'h0, a_dec}, 16'h0000);
		chk({15'h0, inh}, 16'h0001);
		chk({12'h0, a_s7}, 16'h000F);
		chk({12'h0, cbit(9)}, 16'h000F);
		chk({12'h0, irq}, 16'h000F);
		emg_n <= 1'b1;
		tick(6);
		chk({15'h0, inh}, 16'h0000);
		// Software recovery after the emergency halt
		uncause();
		// Emergency command
		clr();
		send(8'h05, 4'h0);
		tick(3);
		chk({12'h0, a_imm}, 16'h000F);
		chk({12'h0, cbit(9)}, 16'h000F);
		give_verdict();
	end
endmodule
